/* File: sat_shift_pkg.sv */
package sat_shift_pkg;

  // ********************************************************
  // Bus and data widths
  // ********************************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W  = 6;

  // ********************************************************
  // Register byte offsets
  // ********************************************************
  localparam logic [7:0] OFS_INSTR    = 8'h00;
  localparam logic [7:0] OFS_SRC1     = 8'h04;
  localparam logic [7:0] OFS_SRC2     = 8'h08;
  localparam logic [7:0] OFS_LIMM     = 8'h0C;
  localparam logic [7:0] OFS_CTRL     = 8'h10;
  localparam logic [7:0] OFS_RESULT   = 8'h14;
  localparam logic [7:0] OFS_FLAGS    = 8'h18;
  localparam logic [7:0] OFS_INFO     = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h28;

  // ********************************************************
  // Instruction fields and encodings
  // ********************************************************
  localparam int unsigned MAJ_HI  = 31;
  localparam int unsigned MAJ_LO  = 27;
  localparam int unsigned FMT_HI  = 23;
  localparam int unsigned FMT_LO  = 22;
  localparam int unsigned SUB_HI  = 21;
  localparam int unsigned SUB_LO  = 16;
  localparam int unsigned F_BIT   = 15;
  localparam logic [4:0]  MAJ_EXT  = 5'h05;
  localparam logic [4:0]  MAJ_BASE = 5'h04;
  localparam logic [5:0]  SUB_SATL = 6'h0A;
  localparam logic [5:0]  SUB_SATR = 6'h0B;
  localparam logic [5:0]  SUB_ASRM = 6'h02;
  localparam logic [5:0]  SUB_SOP  = 6'h2F;
  localparam logic [5:0]  SOP_ASR1 = 6'h01;
  localparam logic [5:0]  LIMM_REG = 6'h3E;
  localparam logic [1:0]  FMT_RRR  = 2'h0;
  localparam logic [1:0]  FMT_U6   = 2'h1;
  localparam logic [1:0]  FMT_S12  = 2'h2;
  localparam logic [1:0]  FMT_COND = 2'h3;

  // ********************************************************
  // Predicate codes
  // ********************************************************
  localparam logic [4:0] CC_AL = 5'h00;
  localparam logic [4:0] CC_EQ = 5'h01;
  localparam logic [4:0] CC_NE = 5'h02;
  localparam logic [4:0] CC_PL = 5'h03;
  localparam logic [4:0] CC_MI = 5'h04;
  localparam logic [4:0] CC_CS = 5'h05;
  localparam logic [4:0] CC_CC = 5'h06;
  localparam logic [4:0] CC_VS = 5'h07;
  localparam logic [4:0] CC_VC = 5'h08;

  // ********************************************************
  // Saturation limits and shift bounds
  // ********************************************************
  localparam logic [31:0] SAT_POS   = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG   = 32'h8000_0000;
  localparam logic [31:0] SHIFT_MAX = 32'h0000_001F;
  localparam logic [31:0] SHIFT_MIN = 32'hFFFF_FFE1;
  localparam logic [4:0]  CLAMP_AMT = 5'h1F;

  // ********************************************************
  // Flag, interrupt, info and control bit positions
  // ********************************************************
  localparam int unsigned FLG_Z  = 0;
  localparam int unsigned FLG_N  = 1;
  localparam int unsigned FLG_C  = 2;
  localparam int unsigned FLG_V  = 3;
  localparam int unsigned FLG_S  = 4;
  localparam int unsigned FLG_SH = 5;
  localparam int unsigned FLG_SL = 6;
  localparam int unsigned FLAGS_W = 7;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_SAT  = 1;
  localparam int unsigned IRQ_BAD  = 2;
  localparam int unsigned IRQ_W    = 3;
  localparam int unsigned INFO_WROTE = 8;
  localparam int unsigned INFO_EXEC  = 9;
  localparam int unsigned CTRL_GO    = 0;

  typedef enum logic [3:0] {
    OP_NONE = 4'h1,
    OP_SATL = 4'h2,
    OP_ASRM = 4'h4,
    OP_ASR1 = 4'h8
  } shift_op_type;

endpackage

/* File: sat_shift_core.sv */
module sat_shift_core
  import sat_shift_pkg::*;
(
  // Operation and operands
  input  wire shift_op_type op,
  input  wire logic [31:0]  src1,
  input  wire logic [31:0]  src2,
  // Outcome
  output logic [31:0]       result,
  output logic              sat,
  output logic              carry
);

  logic [63:0] wide;
  logic [31:0] neg2;
  logic [4:0]  amt;

  always_comb
  begin
    result = '0;
    sat    = 1'b0;
    carry  = 1'b0;
    wide   = {{32{src1[31]}}, src1} << src2[4:0];
    neg2   = 32'(~src2 + 32'h0000_0001);
    amt    = src2[4:0];
    case (op)
      OP_SATL:
      begin
        if (!src2[31] && (src2 > SHIFT_MAX))
        begin
          // A zero source stays zero and does not saturate.
          sat    = |src1;                                  // [RULE2]
          result = src1[31] ? SAT_NEG : (|src1 ? SAT_POS : '0);
        end
        else if (!src2[31])
        begin
          result = wide[31:0];                             // [RULE1]
          if (!((&wide[63:31]) || !(|wide[63:31])))
          begin
            sat    = 1'b1;                                 // [RULE17]
            result = src1[31] ? SAT_NEG : SAT_POS;
          end
        end
        else
        begin
          if ($signed(src2) < $signed(SHIFT_MIN))
            amt = CLAMP_AMT;                               // [RULE4]
          else
            amt = neg2[4:0];
          result = 32'($signed(src1) >>> amt);        // [RULE3] [RULE8]
        end
      end
      OP_ASRM:
      begin
        result = 32'($signed(src1) >>> amt);               // [RULE11]
        carry  = (amt == 5'h00) ? 1'b0 : src1[5'(amt - 5'h01)]; // [RULE12]
      end
      OP_ASR1:
      begin
        result = {src1[31], src1[31:1]};                   // [RULE9]
        carry  = src1[0];
      end
      default:
      begin
        result = '0;
      end
    endcase
  end

endmodule

/* File: sat_shift_unit.sv */
// Behaviour
// RULE1 - Left shift 0..31 then saturate, write
// RULE2 - Amount above 31 forces saturated limit value
// RULE3 - Negative amount shifts right arithmetically
// RULE4 - Amount below -31 clamps to -31
// RULE5 - Saturation sets both channel saturation flags
// RULE6 - Flags change only with flag-update bit
// RULE7 - Zero and negative flags from result
// RULE8 - Right shifts fill with sign bit
// RULE9 - Single shift right keeps sign bit
// RULE10 - Single shift: Z, N, C updated, V kept
// RULE11 - Multi shift uses low five distance bits
// RULE12 - Carry zero, else bit distance minus one
// RULE13 - Multi shift runs only if predicate true
// RULE14 - Long immediate second operand via C=111110
// RULE15 - Saturating right shift long-immediate form recognised; the code leaves op at OP_NONE and refuses it as bad
// RULE16 - Saturation sets sticky flag, carry kept
// RULE17 - Out-of-range result clamps by source sign
// RULE18 - Null destination discards result, keeps flags
module sat_shift_unit
  import sat_shift_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Register file write-back
  output logic                   wb_valid,
  output logic [REG_W-1:0]       wb_index,
  output logic [31:0]            wb_data,
  // Interrupt
  output logic                   irq
);

  // ********************************************************
  // Registers
  // ********************************************************
  logic [31:0]        instr_r,    instr_nxt;
  logic [31:0]        src1_r,     src1_nxt;
  logic [31:0]        src2_r,     src2_nxt;
  logic [31:0]        limm_r,     limm_nxt;
  logic [31:0]        result_r,   result_nxt;
  logic [FLAGS_W-1:0] flags_r,    flags_nxt;
  logic [REG_W-1:0]   dest_r,     dest_nxt;
  logic               wrote_r,    wrote_nxt;
  logic               exec_r,     exec_nxt;
  logic               go_r,       go_nxt;
  logic [IRQ_W-1:0]   irq_stat_r, irq_stat_nxt;
  logic [IRQ_W-1:0]   irq_en_r,   irq_en_nxt;
  logic               irq_r,      irq_nxt;
  logic [31:0]        prdata_r,   prdata_nxt;
  logic               pready_r,   pready_nxt;
  logic               pslverr_r,  pslverr_nxt;
  logic               wb_valid_r, wb_valid_nxt;
  logic [REG_W-1:0]   wb_index_r, wb_index_nxt;
  logic [31:0]        wb_data_r,  wb_data_nxt;

  // ********************************************************
  // Bus decode
  // ********************************************************
  logic        setup;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_mux;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_r;
  always_comb
  begin
    hit    = 1'b1;
    rd_mux = '0;
    if (paddr == OFS_INSTR)
      rd_mux = instr_r;
    else if (paddr == OFS_SRC1)
      rd_mux = src1_r;
    else if (paddr == OFS_SRC2)
      rd_mux = src2_r;
    else if (paddr == OFS_LIMM)
      rd_mux = limm_r;
    else if (paddr == OFS_CTRL || paddr == OFS_IRQ_CLR)
      rd_mux = '0;
    else if (paddr == OFS_RESULT)
      rd_mux = result_r;
    else if (paddr == OFS_FLAGS)
      rd_mux = 32'(flags_r);
    else if (paddr == OFS_INFO)
    begin
      rd_mux[REG_W-1:0]  = dest_r;
      rd_mux[INFO_WROTE] = wrote_r;
      rd_mux[INFO_EXEC]  = exec_r;
    end
    else if (paddr == OFS_IRQ_STAT)
      rd_mux = 32'(irq_stat_r);
    else if (paddr == OFS_IRQ_EN)
      rd_mux = 32'(irq_en_r);
    else
      hit = 1'b0;
  end

  // ********************************************************
  // Bus response
  // ********************************************************
  // Answer is formed in setup, so access needs no wait state.
  always_comb
  begin
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup)
    begin
      prdata_nxt  = pwrite ? '0 : rd_mux;
      pready_nxt  = 1'b1;
      pslverr_nxt = !hit;
    end
  end

  // ********************************************************
  // Instruction decode
  // ********************************************************
  logic [4:0]       maj;
  logic [1:0]       fmt;
  logic [5:0]       sub;
  logic [5:0]       bfld;
  logic [5:0]       cfld;
  logic [5:0]       afld;
  logic             fbit;
  shift_op_type     op;
  logic             bad;
  logic [31:0]      op1;
  logic [31:0]      op2;
  logic [REG_W-1:0] dest;
  logic             pred;
  assign maj  = instr_r[MAJ_HI:MAJ_LO];
  assign fmt  = instr_r[FMT_HI:FMT_LO];
  assign sub  = instr_r[SUB_HI:SUB_LO];
  assign fbit = instr_r[F_BIT];
  assign bfld = {instr_r[14:12], instr_r[26:24]};
  assign cfld = instr_r[11:6];
  assign afld = instr_r[5:0];
  function automatic logic cc_eval(logic [4:0] cc, logic [FLAGS_W-1:0] f);
    case (cc)
      CC_AL:   cc_eval = 1'b1;
      CC_EQ:   cc_eval = f[FLG_Z];
      CC_NE:   cc_eval = !f[FLG_Z];
      CC_PL:   cc_eval = !f[FLG_N];
      CC_MI:   cc_eval = f[FLG_N];
      CC_CS:   cc_eval = f[FLG_C];
      CC_CC:   cc_eval = !f[FLG_C];
      CC_VS:   cc_eval = f[FLG_V];
      CC_VC:   cc_eval = !f[FLG_V];
      default: cc_eval = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    op   = OP_NONE;
    op1  = (bfld == LIMM_REG) ? limm_r : src1_r;
    op2  = src2_r;
    dest = (fmt[1]) ? bfld : afld;
    pred = 1'b1;
    if (maj == MAJ_EXT)
    begin
      if (sub == SUB_SATL)
        op = OP_SATL;
      else if (sub == SUB_ASRM)
        op = OP_ASRM;
      // Saturating right shift, long-immediate form too, is refused.
      else if (sub == SUB_SATR)
        op1 = (bfld == LIMM_REG) ? limm_r : src1_r;      // [RULE15]
      case (fmt)
        FMT_RRR:
          op2 = (cfld == LIMM_REG) ? limm_r : src2_r;    // [RULE14]
        FMT_U6:
          op2 = 32'(cfld);
        FMT_S12:
          op2 = {{20{afld[5]}}, afld, cfld};
        default:
        begin
          op2  = afld[5] ? 32'(cfld) : ((cfld == LIMM_REG) ? limm_r : src2_r);
          pred = cc_eval(afld[4:0], flags_r);            // [RULE13]
        end
      endcase
    end
    else if (maj == MAJ_BASE && sub == SUB_SOP && afld == SOP_ASR1)
    begin
      op   = OP_ASR1;
      dest = bfld;
      if (fmt == FMT_U6)
        op1 = 32'(cfld);
      else
        op1 = (cfld == LIMM_REG) ? limm_r : src2_r;
    end
    bad  = (op == OP_NONE);
  end

  // ********************************************************
  // Shift datapath
  // ********************************************************
  logic [31:0] sh_res;
  logic        sh_sat;
  logic        sh_carry;
  sat_shift_core u_core (
    .op     (op),
    .src1   (op1),
    .src2   (op2),
    .result (sh_res),
    .sat    (sh_sat),
    .carry  (sh_carry)
  );

  // ********************************************************
  // Execution and flags
  // ********************************************************
  logic             run;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  assign run = go_r && !bad && pred;
  always_comb
  begin
    instr_nxt    = instr_r;
    src1_nxt     = src1_r;
    src2_nxt     = src2_r;
    limm_nxt     = limm_r;
    result_nxt   = result_r;
    flags_nxt    = flags_r;
    dest_nxt     = dest_r;
    wrote_nxt    = wrote_r;
    exec_nxt     = exec_r;
    irq_en_nxt   = irq_en_r;
    go_nxt       = 1'b0;
    clr          = '0;
    ev           = '0;
    wb_valid_nxt = 1'b0;
    wb_index_nxt = wb_index_r;
    wb_data_nxt  = wb_data_r;
    if (wr_en)
    begin
      if (paddr == OFS_INSTR)
        instr_nxt = pwdata;
      else if (paddr == OFS_SRC1)
        src1_nxt = pwdata;
      else if (paddr == OFS_SRC2)
        src2_nxt = pwdata;
      else if (paddr == OFS_LIMM)
        limm_nxt = pwdata;
      else if (paddr == OFS_CTRL)
        go_nxt = pwdata[CTRL_GO];
      else if (paddr == OFS_FLAGS)
        flags_nxt = pwdata[FLAGS_W-1:0];
      else if (paddr == OFS_IRQ_CLR)
        clr = pwdata[IRQ_W-1:0];
      else if (paddr == OFS_IRQ_EN)
        irq_en_nxt = pwdata[IRQ_W-1:0];
    end
    // Hardware results override a same-cycle software flag write.
    if (go_r)
    begin
      ev[IRQ_DONE] = 1'b1;
      ev[IRQ_BAD]  = bad;
      exec_nxt     = run;
      wrote_nxt    = 1'b0;
      dest_nxt     = dest;
    end
    if (run)
    begin
      ev[IRQ_SAT] = sh_sat && op == OP_SATL;
      if (dest != LIMM_REG)
      begin
        result_nxt   = sh_res;                             // [RULE18]
        wrote_nxt    = 1'b1;
        wb_valid_nxt = 1'b1;
        wb_index_nxt = dest;
        wb_data_nxt  = sh_res;
      end
      if (fbit)                                            // [RULE6]
      begin
        flags_nxt[FLG_Z] = (sh_res == '0);                 // [RULE7]
        flags_nxt[FLG_N] = sh_res[31];                     // [RULE7]
        if (op == OP_SATL)
        begin
          flags_nxt[FLG_V] = sh_sat;
          if (sh_sat)
          begin
            flags_nxt[FLG_S]  = 1'b1;                      // [RULE16]
            flags_nxt[FLG_SH] = 1'b1;                      // [RULE5]
            flags_nxt[FLG_SL] = 1'b1;                      // [RULE5]
          end
        end
        else
          flags_nxt[FLG_C] = sh_carry;                     // [RULE10]
      end
    end
    // A new event wins over a clear of the same bit.
    irq_stat_nxt = (irq_stat_r & ~clr) | ev;
    irq_nxt      = |(irq_stat_nxt & irq_en_nxt);
  end
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      instr_r    <= '0;
      src1_r     <= '0;
      src2_r     <= '0;
      limm_r     <= '0;
      result_r   <= '0;
      flags_r    <= '0;
      dest_r     <= '0;
      wrote_r    <= 1'b0;
      exec_r     <= 1'b0;
      go_r       <= 1'b0;
      irq_stat_r <= '0;
      irq_en_r   <= '0;
      irq_r      <= 1'b0;
      wb_valid_r <= 1'b0;
      wb_index_r <= '0;
      wb_data_r  <= '0;
      prdata_r   <= '0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end
    else
    begin
      instr_r    <= instr_nxt;
      src1_r     <= src1_nxt;
      src2_r     <= src2_nxt;
      limm_r     <= limm_nxt;
      result_r   <= result_nxt;
      flags_r    <= flags_nxt;
      dest_r     <= dest_nxt;
      wrote_r    <= wrote_nxt;
      exec_r     <= exec_nxt;
      go_r       <= go_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_en_r   <= irq_en_nxt;
      irq_r      <= irq_nxt;
      wb_valid_r <= wb_valid_nxt;
      wb_index_r <= wb_index_nxt;
      wb_data_r  <= wb_data_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign wb_valid = wb_valid_r;
  assign wb_index = wb_index_r;
  assign wb_data  = wb_data_r;
  assign irq      = irq_r;
endmodule

/* File: sat_shift_checker.sv */
module sat_shift_checker
  import sat_shift_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              arst_n,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Write-back and interrupt
  input wire logic              wb_valid,
  input wire logic [REG_W-1:0]  wb_index,
  input wire logic [31:0]       wb_data,
  input wire logic              irq
);
  logic [31:0]        ins_r;
  logic [31:0]        s1_r;
  logic signed [31:0] amt;
  logic               ext;
  logic               rr;
  logic               satl;
  logic               go;

  // ****************************************
  // Shadow of the operand registers
  // ****************************************
  // Plain register forms only: no long immediate is shadowed.
  assign ext  = ins_r[MAJ_HI:MAJ_LO] == MAJ_EXT;
  assign rr   = ext && ins_r[FMT_HI:FMT_LO] == FMT_RRR
    && ins_r[11:6] != LIMM_REG && {ins_r[14:12], ins_r[26:24]} != LIMM_REG;
  assign satl = wb_valid && rr && ins_r[SUB_HI:SUB_LO] == SUB_SATL;
  assign go   = psel && penable && pready && pwrite && paddr == OFS_CTRL
    && pwdata[CTRL_GO];

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ins_r <= '0;
      s1_r  <= '0;
      amt   <= '0;
    end
    else if (psel && penable && pready && pwrite)
    begin
      ins_r <= (paddr == OFS_INSTR) ? pwdata : ins_r;
      s1_r  <= (paddr == OFS_SRC1) ? pwdata : s1_r;
      amt   <= (paddr == OFS_SRC2) ? $signed(pwdata) : amt;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence go_s;
    go;
  endsequence

  AST_SAT_BIG:
    assert property (satl && amt > 31 && s1_r != '0
      |-> wb_data == (s1_r[31] ? SAT_NEG : SAT_POS))
      else $error("limit value wrong");
  AST_SAT_CLAMP:
    assert property (satl && amt < -31 |-> wb_data == {32{s1_r[31]}})
      else $error("clamped right shift wrong");
  AST_SAT_RIGHT:
    assert property (satl && amt < 0 && amt >= -31
      |-> wb_data == 32'($signed(s1_r) >>> (-amt)))
      else $error("negative amount shift wrong");
  AST_MULTI_ASR:
    assert property (wb_valid && rr && ins_r[SUB_HI:SUB_LO] == SUB_ASRM
      |-> wb_data == 32'($signed(s1_r) >>> amt[4:0]))
      else $error("multi shift wrong");
  AST_WB_DEST:
    assert property (wb_valid && rr |-> wb_index == ins_r[5:0])
      else $error("destination wrong");
  AST_WB_CAUSE:
    assert property (wb_valid |-> $past(go, 2))
      else $error("write-back without start");
  AST_NULL_DEST:
    assert property (go_s ##0 (rr && ins_r[5:0] == LIMM_REG) |-> ##2 !wb_valid)
      else $error("null destination written");
  AST_COND_FALSE:
    assert property (go_s ##0 (ext && ins_r[FMT_HI:FMT_LO] == FMT_COND
      && ins_r[4:0] > CC_VC) |-> ##2 !wb_valid)
      else $error("false predicate wrote");
  AST_READY:
    assert property (psel && !penable |=> pready)
      else $error("ready missing");
  AST_SLVERR:
    assert property (psel && !penable && paddr > OFS_IRQ_EN
      |=> pslverr && prdata == '0)
      else $error("unmapped access not refused");
endmodule

bind sat_shift_unit sat_shift_checker u_chk (
  .clk_sys (clk_sys),
  .arst_n  (arst_n),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .prdata  (prdata),
  .pready  (pready),
  .pslverr (pslverr),
  .wb_valid(wb_valid),
  .wb_index(wb_index),
  .wb_data (wb_data),
  .irq     (irq)
);

/* File: tb_saturating_shift_unit.sv */
module tb_saturating_shift_unit
  import sat_shift_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys;
  logic              arst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              wb_valid;
  logic [REG_W-1:0]  wb_index;
  logic [31:0]       wb_data;
  logic              irq;
  int                errors = 0;
  int                check_count = 0;
  int                cycles = 0;
  int                seed = 32'h48AA;
  int                k;
  logic [31:0]       rd;
  logic              er;
  logic [31:0]       s1;
  logic [31:0]       s2;
  logic [31:0]       ins;
  logic [32:0]       e;
  logic [6:0]        p;
  logic [6:0]        ef;
  logic [5:0]        a;
  logic              f;
  logic              c;
  logic [31:0] c1 [0:4] = '{32'h1000_1111, 32'hFFFF_EEEF, 32'h0, 32'h1,
                            32'hFFFF_FFFF};
  logic [31:0] c2 [0:13] = '{32'h0, 32'h1, 32'h3, 32'h1F, 32'h20, 32'h21,
    32'hFFFF_FFFF, 32'hFFFF_FFF4, 32'hFFFF_FFF3, 32'hFFFF_FFE1,
    32'hFFFF_FFE0, 32'hFFFF_FF9C, 32'h7FFF_FFFE, 32'h8000_0001};

  sat_shift_unit DUT (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .wb_valid(wb_valid),
    .wb_index(wb_index),
    .wb_data (wb_data),
    .irq     (irq)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Expectations
  // ****************************************
  function automatic logic [31:0] enc(logic [4:0] mj, logic [1:0] fm,
    logic [5:0] sb, logic fl, logic [5:0] b, logic [5:0] cf, logic [5:0] d);
    return {mj, b[2:0], fm, sb, fl, b[5:3], cf, d};
  endfunction

  // Returns the saturation indication above the 32-bit result.
  function automatic logic [32:0] exp_satl(logic [31:0] x, logic [31:0] y);
    logic signed [63:0] full;
    int                 amt;
    if ($signed(y) > 31)
      return (x == 32'h0) ? 33'h0 : {1'b1, x[31] ? SAT_NEG : SAT_POS};
    full = {{32{x[31]}}, x};
    full = full <<< y[4:0];
    if ($signed(y) >= 0)
      return (full > 64'sh7FFF_FFFF) ? {1'b1, SAT_POS}
           : (full < -64'sh8000_0000) ? {1'b1, SAT_NEG} : {1'b0, full[31:0]};
    amt = ($signed(y) < -31) ? 31 : -$signed(y);
    return {1'b0, 32'($signed(x) >>> amt)};
  endfunction

  function automatic logic [32:0] exp_asr(logic [31:0] x, logic [4:0] d);
    return {(d == 5'h0) ? 1'b0 : x[d - 5'h1], 32'($signed(x) >>> d)};
  endfunction

  function automatic logic [6:0] flg(logic [6:0] q, logic [32:0] r,
                                     logic fl, logic sl);
    logic [6:0] n;
    n = q;
    if (fl)
    begin
      n[FLG_Z] = r[31:0] == 32'h0;
      n[FLG_N] = r[31];
      if (sl)
      begin
        n[FLG_V] = r[32];
        n[6:4]   = q[6:4] | {3{r[32]}};
      end
      else
        n[FLG_C] = r[32];
    end
    return n;
  endfunction

  function automatic logic pred(logic [4:0] q, logic [6:0] v);
    case (q)
      CC_AL:   return 1'b1;
      CC_EQ:   return v[FLG_Z];
      CC_NE:   return !v[FLG_Z];
      CC_PL:   return !v[FLG_N];
      CC_MI:   return v[FLG_N];
      CC_CS:   return v[FLG_C];
      CC_CC:   return !v[FLG_C];
      CC_VS:   return v[FLG_V];
      CC_VC:   return !v[FLG_V];
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************
  // Bus and checking tasks
  // ****************************************
  task automatic chk(logic [31:0] got, logic [31:0] xp, string what);
    check_count++;
    if (got !== xp)
    begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, xp);
    end
  endtask

  task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic exec(logic [31:0] i1, x, y, lim, logic [6:0] q, logic wb,
    logic [5:0] d, logic [31:0] r, logic [6:0] qf, logic ex);
    apb(1'b1, OFS_INSTR, i1);
    apb(1'b1, OFS_SRC1, x);
    apb(1'b1, OFS_SRC2, y);
    apb(1'b1, OFS_LIMM, lim);
    apb(1'b1, OFS_FLAGS, {25'h0, q});
    apb(1'b1, OFS_CTRL, 32'h1);
    @(posedge clk_sys);
    #1;
    chk(wb_valid, wb, "write-back strobe");
    if (wb)
    begin
      chk(wb_index, d, "destination");
      chk(wb_data, r, "write-back data");
      apb(1'b0, OFS_RESULT, 32'h0);
      chk(rd, r, "result register");
    end
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk(rd, {25'h0, qf}, "flags");
    apb(1'b0, OFS_INFO, 32'h0);
    chk(rd[INFO_EXEC], ex, "executed");
  endtask

  task automatic summarize();
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      summarize();
    end
  end

  initial
  begin
    arst_n  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 90; i++)
    begin
      k  = i % 30;
      s1 = (k % 3 == 0) ? c1[k % 5] : $random(seed);
      s2 = (k < 14) ? c2[k]
         : ((k % 2) ? 32'($random(seed) % 40) : $random(seed));
      p  = 7'($random(seed));
      f  = (k % 4) != 3;
      a  = 6'({$random(seed)} % 62);
      ins = (i < 30) ? enc(MAJ_EXT, FMT_RRR, SUB_SATL, f, 6'h01, 6'h02, a)
          : (i < 60) ? enc(MAJ_EXT, FMT_RRR, SUB_ASRM, f, 6'h01, 6'h02, a)
          : enc(MAJ_BASE, FMT_RRR, SUB_SOP, f, a, 6'h02, SOP_ASR1);
      case (i / 30)
        0:       e = exp_satl(s1, s2);
        1:       e = exp_asr(s1, s2[4:0]);
        default: e = exp_asr(s2, 5'h01);
      endcase
      ef = flg(p, e, f, i < 30);
      exec(ins, s1, s2, 32'h0, p, 1'b1, a, e[31:0], ef, 1'b1);
    end
    ins = enc(MAJ_EXT, FMT_RRR, SUB_ASRM, 1'b1, 6'h01, LIMM_REG, 6'h05);
    exec(ins, 32'h8000_0010, 32'hFF, 32'h4, 7'h00, 1'b1, 6'h05,
         32'hF800_0001, 7'h02, 1'b1);
    ins = enc(MAJ_EXT, FMT_RRR, SUB_SATL, 1'b1, 6'h01, 6'h02, LIMM_REG);
    exec(ins, 32'h1, 32'h28, 32'h0, 7'h00, 1'b0,
         6'h00, 32'h0, 7'h78, 1'b1);
    for (int q = 0; q < 10; q++)
    begin
      p   = 7'($random(seed));
      s1  = $random(seed);
      e   = exp_asr(s1, 5'h03);
      ins = enc(MAJ_EXT, FMT_COND, SUB_ASRM, 1'b1, 6'h04, 6'h02, 6'(q));
      c   = pred(5'(q), p);
      exec(ins, s1, 32'h3, 32'h0, p, c, 6'h04, e[31:0],
           c ? flg(p, e, 1'b1, 1'b0) : p, c);
    end
    apb(1'b1, OFS_IRQ_CLR, 32'h7);
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    ins = enc(MAJ_EXT, FMT_RRR, SUB_SATR, 1'b1, LIMM_REG, 6'h02, 6'h03);
    exec(ins, 32'h5, 32'h1, 32'h10, 7'h15, 1'b0,
         6'h00, 32'h0, 7'h15, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h5, "interrupt status");
    chk(irq, 1'b0, "masked interrupt");
    apb(1'b1, OFS_IRQ_EN, 32'h4);
    @(posedge clk_sys);
    #1;
    chk(irq, 1'b1, "interrupt raised");
    apb(1'b1, OFS_IRQ_CLR, 32'h7);
    @(posedge clk_sys);
    #1;
    chk(irq, 1'b0, "interrupt cleared");
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0, "status after clear");
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    summarize();
  end
endmodule
